// file: hdl/smd_consts.svh
// Constant definitions for the shared mono display serial port.
`ifndef SMD_CONSTS_SVH
`define SMD_CONSTS_SVH
`define SMD_LINE_BITS 128
`define SMD_LINES 128
`define SMD_ROW_W 7
`define SMD_BIT_W 7
`define SMD_FIFO_DEPTH 32
`define SMD_CLK_HZ 200000000
`define SMD_SCLK_MAX_HZ 1100000
`define SMD_SCLK_MIN_CYC \
   ((`SMD_CLK_HZ + `SMD_SCLK_MAX_HZ - 1) / `SMD_SCLK_MAX_HZ)
`define SMD_COM_TIMEOUT_MS 1000
`define SMD_COM_TIMEOUT_CYC ((`SMD_CLK_HZ / 1000) * `SMD_COM_TIMEOUT_MS)
`define SMD_ROW_RESET 7'h00
`endif

// file: hdl/smd_fifo.sv
// Parameterised valid/ready FIFO used for completed display lines.
`timescale 1ns/1ps
module smd_fifo
#(
   parameter int WIDTH = 135,
   parameter int DEPTH = 32
)
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointers wrap by power of two, so other depths are refused.
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
   begin
      $error("smd_fifo: DEPTH must be a power of two >= 2");
   end

   typedef struct packed
   {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
   } smd_fifo_state_t;

   smd_fifo_state_t st_reg;
   smd_fifo_state_t st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready_o = (st_reg.count != (AW+1)'(DEPTH));
   assign out_valid_o = (st_reg.count != '0);
   assign out_data_o = mem[st_reg.rptr];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // Pointer and count update; simultaneous push and pop keep the count.
   always_comb
   begin
      st_next = st_reg;
      if (push)
      begin
         st_next.wptr = st_reg.wptr + 1'b1;
      end
      if (pop)
      begin
         st_next.rptr = st_reg.rptr + 1'b1;
      end
      if (push && !pop)
      begin
         st_next.count = st_reg.count + 1'b1;
      end
      else if (pop && !push)
      begin
         st_next.count = st_reg.count - 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Storage has no reset; only the count and pointers say what is valid.
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[st_reg.wptr] <= in_data_i;
      end
   end
endmodule

// file: hdl/smd_pkg.sv
// Types shared by the display port and its line FIFO.
`include "smd_consts.svh"
package smd_pkg;
   // One complete display line together with the row it lands in.
   typedef struct packed
   {
      logic [`SMD_ROW_W-1:0] row;
      logic [`SMD_LINE_BITS-1:0] pix;
   } smd_line_t;
endpackage

// file: hdl/smd_port.sv
// Serial line-write port of the shared 128x128 monochrome display.
`timescale 1ns/1ps
`include "smd_consts.svh"
module smd_port
#(
   parameter int COM_TIMEOUT_CYC = `SMD_COM_TIMEOUT_CYC
)
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic display_owner_select,
   input wire logic display_chip_select,
   input wire logic display_serial_clock,
   input wire logic display_serial_in,
   input wire logic com_inversion_pulse,
   input wire logic panel_ready_i,
   input wire logic [`SMD_ROW_W-1:0] rd_row_i,
   output logic [`SMD_LINE_BITS-1:0] rd_pix_o,
   output logic owner_target_o,
   output logic frame_active_o,
   output logic line_drop_o,
   output logic sclk_overspeed_o,
   output logic com_polarity_o,
   output logic com_stale_o
);
   localparam int LW = $bits(smd_pkg::smd_line_t);
   localparam logic [7:0] MIN_CYC = 8'(`SMD_SCLK_MIN_CYC);
   localparam logic [31:0] COM_LIMIT = 32'(COM_TIMEOUT_CYC);

   // The watchdog compares against limit minus one, so tiny limits break.
   if (COM_TIMEOUT_CYC < 2)
   begin
      $error("smd_port: COM_TIMEOUT_CYC must be at least 2");
   end

   // The counters below are sized from the constants; refuse mismatches.
   if (`SMD_LINE_BITS != (1 << `SMD_BIT_W))
   begin
      $error("smd_port: line width must be two to the bit counter width");
   end
   if (`SMD_LINES > (1 << `SMD_ROW_W))
   begin
      $error("smd_port: row pointer too narrow for the line count");
   end
   if (`SMD_SCLK_MIN_CYC < 2 || `SMD_SCLK_MIN_CYC > 255)
   begin
      $error("smd_port: minimum serial clock period must fit the counter");
   end

   typedef struct packed
   {
      logic own_s1;
      logic own_s2;
      logic cs_s1;
      logic cs_s2;
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_d;
      logic si_s1;
      logic si_s2;
      logic com_s1;
      logic com_s2;
      logic com_d;
      logic [`SMD_LINE_BITS-1:0] shift;
      logic [`SMD_BIT_W-1:0] bit_cnt;
      logic [`SMD_ROW_W-1:0] row;
      logic [7:0] per_cnt;
      logic seen_edge;
      logic overspeed;
      logic drop;
      logic com_pol;
      logic [31:0] com_cnt;
      logic com_stale;
      logic [`SMD_LINE_BITS-1:0] rd_pix;
   } smd_port_state_t;

   smd_port_state_t st_reg;
   smd_port_state_t st_next;
   logic [`SMD_LINE_BITS-1:0] pix_mem [`SMD_LINES];
   smd_pkg::smd_line_t wr_line;
   smd_pkg::smd_line_t rd_line;
   logic wr_valid;
   logic wr_ready;
   logic rd_valid;
   logic sclk_rise;
   logic com_edge;

   // Edges are taken from the second and third stages only.
   assign sclk_rise = st_reg.sclk_s2 & ~st_reg.sclk_d;
   assign com_edge = st_reg.com_s2 ^ st_reg.com_d;

   // Lines wait here until the panel can take them into the glass.
   smd_fifo
   #(
      .WIDTH(LW),
      .DEPTH(`SMD_FIFO_DEPTH)
   )
   u_line_fifo
   (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(wr_valid),
      .in_ready_o(wr_ready),
      .in_data_i(wr_line),
      .out_valid_o(rd_valid),
      .out_ready_i(panel_ready_i),
      .out_data_o(rd_line)
   );

   // Synchronisers, line shifter, clock speed watch and com watchdog.
   always_comb
   begin
      st_next = st_reg;
      wr_valid = 1'b0;
      wr_line.row = st_reg.row;
      wr_line.pix = {st_reg.shift[`SMD_LINE_BITS-2:0], st_reg.si_s2};
      st_next.own_s1 = display_owner_select;
      st_next.own_s2 = st_reg.own_s1;
      st_next.cs_s1 = display_chip_select;
      st_next.cs_s2 = st_reg.cs_s1;
      st_next.sclk_s1 = display_serial_clock;
      st_next.sclk_s2 = st_reg.sclk_s1;
      st_next.sclk_d = st_reg.sclk_s2;
      st_next.si_s1 = display_serial_in;
      st_next.si_s2 = st_reg.si_s1;
      st_next.com_s1 = com_inversion_pulse;
      st_next.com_s2 = st_reg.com_s1;
      st_next.com_d = st_reg.com_s2;
      st_next.overspeed = 1'b0;
      st_next.drop = 1'b0;
      if (st_reg.per_cnt != 8'hff)
      begin
         st_next.per_cnt = st_reg.per_cnt + 8'h01;
      end
      if (!st_reg.cs_s2)
      begin
         // A frame cut short leaves no partial line behind.
         st_next.bit_cnt = '0;
         st_next.seen_edge = 1'b0;
      end
      else if (sclk_rise)
      begin
         // One bit per pixel, first bit ends up as the top bit.
         st_next.shift = wr_line.pix;
         st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
         st_next.per_cnt = 8'h00;
         st_next.seen_edge = 1'b1;
         // Compared without an increment, so a saturated count never wraps
         // into a false overspeed after a long pause inside one frame.
         if (st_reg.seen_edge && st_reg.per_cnt < MIN_CYC - 8'h01)
         begin
            st_next.overspeed = 1'b1;
         end
         if (st_reg.bit_cnt == `SMD_BIT_W'(`SMD_LINE_BITS - 1))
         begin
            // A whole line completes; the row advances only if the FIFO takes it, and wraps at 128.
            wr_valid = 1'b1;
            if (wr_ready)
            begin
               st_next.row = st_reg.row + 1'b1;
            end
            else
            begin
               st_next.drop = 1'b1;
            end
         end
      end
      // The panel must see inversion toggles; silence raises a warning.
      if (com_edge)
      begin
         st_next.com_pol = st_reg.com_s2;
         st_next.com_cnt = '0;
         st_next.com_stale = 1'b0;
      end
      else if (st_reg.com_cnt >= COM_LIMIT - 32'h1)
      begin
         st_next.com_stale = 1'b1;
      end
      else
      begin
         st_next.com_cnt = st_reg.com_cnt + 32'h1;
      end
      st_next.rd_pix = pix_mem[rd_row_i];
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_reg <= '0;
         st_reg.row <= `SMD_ROW_RESET;
         st_reg.per_cnt <= 8'hff;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Glass keeps each line until it is overwritten; no refresh needed.
   always_ff @(posedge clk_i)
   begin
      if (rd_valid && panel_ready_i)
      begin
         pix_mem[rd_line.row] <= rd_line.pix;
      end
   end

   // Owner indication follows the synchronised select level.
   assign owner_target_o = st_reg.own_s2;
   assign frame_active_o = st_reg.cs_s2;
   assign line_drop_o = st_reg.drop;
   assign sclk_overspeed_o = st_reg.overspeed;
   assign com_polarity_o = st_reg.com_pol;
   assign com_stale_o = st_reg.com_stale;
   assign rd_pix_o = st_reg.rd_pix;
endmodule

// file: verification/smd_host_model.sv
// Behavioural model of the party that drives the display pins.
`timescale 1ns/1ps
module smd_host_model
(
   input wire logic clk_i,
   output logic owner_o,
   output logic cs_o,
   output logic sclk_o,
   output logic si_o,
   output logic com_o
);
   logic com_on;
   // Pins idle low so a non-owner never contends.
   initial
   begin
      owner_o = 1'b0;
      cs_o = 1'b0;
      sclk_o = 1'b0;
      si_o = 1'b0;
      com_o = 1'b0;
      com_on = 1'b1;
   end
   // The inversion pin keeps toggling unless a test stops it.
   always
   begin
      repeat (50) @(posedge clk_i);
      if (com_on) com_o <= !com_o;
   end
   // Shifts n bits MSB first, one bit per pixel, half period in cycles.
   task automatic send_line(input logic [127:0] d, input int half,
      input int n);
      @(posedge clk_i);
      cs_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      for (int i = 127; i > 127 - n; i--)
      begin
         si_o <= d[i];
         sclk_o <= 1'b0;
         repeat (half) @(posedge clk_i);
         sclk_o <= 1'b1;
         repeat (half) @(posedge clk_i);
      end
      sclk_o <= 1'b0;
      repeat (half) @(posedge clk_i);
      cs_o <= 1'b0;
      si_o <= !si_o; // Released data shows no stale value.
      repeat (4) @(posedge clk_i);
   endtask
endmodule

// file: verification/smd_port_properties.sv
// Concurrent checks on the display port outputs.
`timescale 1ns/1ps
module smd_port_properties
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic display_owner_select,
   input wire logic display_chip_select,
   input wire logic com_inversion_pulse,
   input wire logic owner_target_o,
   input wire logic frame_active_o,
   input wire logic line_drop_o,
   input wire logic com_stale_o
);
   // All checks use the system clock and rest while reset is low.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_owner_target: assert property (
      display_owner_select [*4] |=> owner_target_o)
      else $error("Owner flag missed a held high select.");
   a_owner_super: assert property (
      !display_owner_select [*4] |=> !owner_target_o)
      else $error("Owner flag missed a held low select.");
   a_frame_idle: assert property (
      !display_chip_select [*4] |=> !frame_active_o)
      else $error("Frame flag high with select held low.");
   a_frame_busy: assert property (
      display_chip_select [*4] |=> frame_active_o)
      else $error("Frame flag low with select held high.");
   a_drop_single: assert property (
      line_drop_o |=> !line_drop_o)
      else $error("Drop pulse lasted longer than one cycle.");
   // Staleness may only appear after the pin has been quiet a while.
   a_stale_quiet: assert property (
      $rose(com_stale_o) |->
      com_inversion_pulse == $past(com_inversion_pulse, 8))
      else $error("Stale flag rose right after a toggle.");
endmodule

bind smd_port smd_port_properties smd_port_properties_i
(
   .clk_i(clk_i), .nrst_i(nrst_i),
   .display_owner_select(display_owner_select),
   .display_chip_select(display_chip_select),
   .com_inversion_pulse(com_inversion_pulse),
   .owner_target_o(owner_target_o), .frame_active_o(frame_active_o),
   .line_drop_o(line_drop_o), .com_stale_o(com_stale_o)
);

// file: verification/test_shared_mono_display_port.sv
// Self-checking bench for the display line-write port.
`timescale 1ns/1ps
`include "smd_consts.svh"
module test_shared_mono_display_port;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic panel_ready_i = 1'b0;
   logic [`SMD_ROW_W-1:0] rd_row_i = 7'h00;
   logic [`SMD_LINE_BITS-1:0] rd_pix_o, p;
   logic own, cs, sck, si, com, own_t, frm, drop, ovs, pol, stale;
   int fail_count = 0;
   int cmp_count = 0;
   int ovs_n = 0;
   int drop_n = 0;
   localparam logic [127:0] LA = {4{32'hc3a5_0f01}};
   localparam logic [127:0] LB = {8{16'h8001}};
   smd_host_model smd_host_model_i (.clk_i(clk_i), .owner_o(own),
      .cs_o(cs), .sclk_o(sck), .si_o(si), .com_o(com));
   smd_port #(.COM_TIMEOUT_CYC(200)) smd_port_i (.clk_i(clk_i),
      .nrst_i(nrst_i), .display_owner_select(own),
      .display_chip_select(cs), .display_serial_clock(sck),
      .display_serial_in(si), .com_inversion_pulse(com),
      .panel_ready_i(panel_ready_i), .rd_row_i(rd_row_i),
      .rd_pix_o(rd_pix_o), .owner_target_o(own_t),
      .frame_active_o(frm), .line_drop_o(drop),
      .sclk_overspeed_o(ovs), .com_polarity_o(pol),
      .com_stale_o(stale));
   // Clock of 5 ns period.
   initial
   begin
      forever #2.5 clk_i = !clk_i;
   end
   // Overspeed pulses last one cycle, so they are counted here.
   always @(posedge clk_i) if (ovs === 1'b1) ovs_n++;
   // Drop pulses last one cycle as well.
   always @(posedge clk_i) if (drop === 1'b1) drop_n++;
   task automatic chk(input string nm, input logic [127:0] e, a);
      cmp_count++;
      if (a !== e)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, a);
      end
   endtask
   task automatic rd(input logic [6:0] r);
      @(posedge clk_i);
      rd_row_i <= r;
      repeat (2) @(posedge clk_i);
      #1 p = rd_pix_o;
   endtask
   task automatic t_owner();
      smd_host_model_i.owner_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      #1 chk("owner low", 0, own_t);
      smd_host_model_i.owner_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1 chk("owner high", 1, own_t);
   endtask
   task automatic t_lines();
      smd_host_model_i.send_line(LA, 92, 128);
      chk("slow overspeed", 0, ovs_n);
      smd_host_model_i.send_line(LB, 16, 128);
      chk("fast overspeed", 1, ovs_n > 0);
      smd_host_model_i.send_line(~LA, 16, 40);
      smd_host_model_i.send_line(~LA, 16, 128);
      rd(7'h00);
      chk("row 0", LA, p);
      rd(7'h01);
      chk("row 1", LB, p);
      rd(7'h02);
      chk("row 2 after abort", ~LA, p);
   endtask
   // Stall the panel: 32 lines fill the FIFO and the 33rd is dropped.
   task automatic t_drop();
      @(posedge clk_i);
      panel_ready_i <= 1'b0;
      for (int k = 0; k < 33; k++)
      begin
         smd_host_model_i.send_line(k < 32 ? LB : LA, 4, 128);
      end
      chk("drop count", 1, drop_n);
      @(posedge clk_i);
      panel_ready_i <= 1'b1;
      smd_host_model_i.send_line(~LB, 4, 128);
      rd(7'h22);
      chk("row 34 kept", LB, p);
      rd(7'h23);
      chk("row after drop", ~LB, p);
   endtask
   task automatic t_com();
      chk("com live", 0, stale);
      smd_host_model_i.com_on <= 1'b0;
      repeat (300) @(posedge clk_i);
      #1 chk("com stale", 1, stale);
      chk("com polarity", com, pol);
      smd_host_model_i.com_on <= 1'b1;
      repeat (60) @(posedge clk_i);
      #1 chk("com cleared", 0, stale);
   endtask
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Watchdog sized well above the roughly 70k cycles of traffic.
   initial
   begin
      repeat (90000) @(posedge clk_i);
      fail_count++;
      stop_test();
   end
   // Main sequence.
   initial
   begin
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      panel_ready_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      t_owner();
      t_lines();
      t_drop();
      t_com();
      stop_test();
   end
endmodule
